// ===== src/brte_pkg.sv
package brte_pkg;

  // --------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] REG_CHAIN = 4'h8;
  localparam int CTRL_RUN_EN_BIT = 0;
  localparam logic CTRL_RUN_EN_RESET = 1'h1;

  // --------------------------------------------------------------
  // Boundary chain layout
  // --------------------------------------------------------------
  localparam int CHAIN_W = 18;
  localparam int DIR_BIT = 17;
  localparam int OE_BIT = 16;
  localparam int A_LSB = 8;
  localparam int B_LSB = 0;
  localparam logic [CHAIN_W-1:0] CHAIN_RESET = 18'h1_0000;

  // --------------------------------------------------------------
  // Instruction register
  // --------------------------------------------------------------
  localparam int IR_W = 8;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
  localparam logic [IR_W-1:0] IR_RESET = 8'hFF;
  localparam logic [6:0] IR_RUN_SELECTED_TEST = 7'h09;
  localparam logic [6:0] IR_BOUNDARY_READBACK_NORMAL = 7'h0A;
  localparam logic [6:0] IR_BOUNDARY_READBACK_TESTMODE = 7'h0B;
  localparam logic [6:0] IR_CONTROL_REG_SCAN_NORMAL = 7'h0E;
  localparam logic [6:0] IR_CONTROL_REG_SCAN_TESTMODE = 7'h0F;

  // --------------------------------------------------------------
  // Test-operation select register opcodes
  // --------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_SAMPLE_IN_TOGGLE_OUT = 2'h0,
    OP_PATTERN_GENERATE = 2'h1,
    OP_SIGNATURE_COMPRESS = 2'h2,
    OP_COMBINED_COMPRESS_GENERATE = 2'h3
  } brte_op_e;
  localparam brte_op_e OP_RESET = OP_SAMPLE_IN_TOGGLE_OUT;

  // Maximal-length feedback masks
  localparam logic [15:0] TAPS16 = 16'hB400;
  localparam logic [7:0] TAPS8 = 8'hB8;

  // --------------------------------------------------------------
  // TAP controller states
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_TLR = 4'h0,
    ST_RTI = 4'h1,
    ST_SEL_DR = 4'h3,
    ST_CAP_DR = 4'h2,
    ST_SHIFT_DR = 4'h6,
    ST_EXIT1_DR = 4'h7,
    ST_PAUSE_DR = 4'h5,
    ST_EXIT2_DR = 4'h4,
    ST_UPD_DR = 4'hC,
    ST_SEL_IR = 4'hD,
    ST_CAP_IR = 4'hF,
    ST_SHIFT_IR = 4'hE,
    ST_EXIT1_IR = 4'hA,
    ST_PAUSE_IR = 4'hB,
    ST_EXIT2_IR = 4'h9,
    ST_UPD_IR = 4'h8
  } brte_tap_e;

  // Pins that arrive from outside the clock domain
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic dir;
    logic oe_n;
    logic [7:0] a;
    logic [7:0] b;
  } brte_pins_s;

endpackage

// ===== src/brte_sync.sv
module brte_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // --------------------------------------------------------------
  // Two-flop synchroniser; first stage feeds only the second
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

// ===== src/brte_lfsr_step.sv
module brte_lfsr_step #(
  parameter int W = 8,
  parameter logic [W-1:0] TAPS = '1
) (
  input wire logic [W-1:0] q_i,
  output logic [W-1:0] next_o
);

  // An all-zero word maps onto itself, so a zero seed stays put
  always_comb
  begin
    next_o = {q_i[W-2:0], ^(q_i & TAPS)};
  end

endmodule

// ===== src/brte_engine.sv
// Notes on behaviour
// RQ1: Opcode comes from control register bits 1..0.
// RQ2: Operation runs only under run instruction, idle.
// RQ3: Opcodes: sample/toggle, pattern, signature, combined.
// RQ4: Direction and enable cells excluded from algorithms.
// RQ5: Enable cell decides drive or high impedance.
// RQ6: Direction cell decides which port is input.
// RQ7: Sample mode captures inputs, updates input latches.
// RQ8: Sample mode toggles outputs, drives them on fall.
// RQ9: Pattern mode steps 16-bit pattern, updates all.
// RQ10: Master scans a seed before pattern or signature.
// RQ11: All-zero seed keeps generators at zero.
// RQ12: Signature mode folds inputs into 16-bit signature.
// RQ13: Signature mode holds output latches constant.
// RQ14: Combined mode folds inputs into 8-bit signature.
// RQ15: Combined mode generates 8-bit output pattern.
// RQ16: Sample TDI, TMS, inputs on rising TCK.
// RQ17: TDO and output pins change on falling TCK.
// RQ18: Master changes TMS on falling TCK.
// RQ19: TAP walks reset, idle, select states, capture.
// RQ20: Capture-IR loads fixed value 10000001.
// RQ21: Shift states carry TDI in and TDO out.
// RQ22: Run instruction selects bypass, captures zero.
// RQ23: Control register kept unchanged during Capture-DR.
// RQ24: Readback keeps boundary chain unchanged at capture.
// RQ25: Feedback taps use maximal-length polynomials.
// RQ26: Stop updating cells once idle state is left.
//
// The register addresses and the plain strobed port were decided locally.
module brte_engine (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic dir_i,
  input wire logic oe_n_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic [brte_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic [7:0] a_o,
  output logic a_oe_o,
  output logic [7:0] b_o,
  output logic b_oe_o,
  output logic [7:0] core_data_o
);
  import brte_pkg::*;

  // --------------------------------------------------------------
  // Reset release and pin synchronisation
  // --------------------------------------------------------------
  logic [1:0] rst_pipe;
  logic rst_n;
  brte_pins_s pins_raw;
  brte_pins_s pins;
  logic tck_q;
  logic tck_rise;
  logic tck_fall;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'h1};
  end
  assign rst_n = rst_pipe[1];

  assign pins_raw = '{tck: tck_i, tms: tms_i, tdi: tdi_i, dir: dir_i,
                      oe_n: oe_n_i, a: a_i, b: b_i};

  brte_sync #(
    .W($bits(brte_pins_s))
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(pins_raw),
    .q_o(pins)
  );

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      tck_q <= 1'h0;
    else
      tck_q <= pins.tck;
  end
  assign tck_rise = pins.tck & ~tck_q; // RQ16
  assign tck_fall = ~pins.tck & tck_q; // RQ17

  // Pins follow the shadow one clock after the fall, once the shadow
  // has taken this fall's update; otherwise they would lag one TCK
  logic tck_fall_q;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      tck_fall_q <= 1'h0;
    else
      tck_fall_q <= tck_fall;
  end

  // --------------------------------------------------------------
  // TAP controller
  // --------------------------------------------------------------
  brte_tap_e state;
  brte_tap_e next_state;

  always_comb
  begin
    case (state)
      ST_TLR: next_state = pins.tms ? ST_TLR : ST_RTI; // RQ19
      ST_RTI: next_state = pins.tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: next_state = pins.tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = pins.tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = pins.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = pins.tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: next_state = pins.tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: next_state = pins.tms ? ST_TLR : ST_CAP_IR; // RQ19
      ST_CAP_IR: next_state = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = pins.tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = pins.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = pins.tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: next_state = pins.tms ? ST_SEL_DR : ST_RTI;
      default: next_state = ST_TLR;
    endcase
  end

  // TMS is only looked at on rising TCK, so a master moving it on
  // the falling edge always meets a settled level
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_TLR;
    else if (tck_rise)
      state <= next_state; // RQ18
  end

  // --------------------------------------------------------------
  // Instruction register and decode
  // --------------------------------------------------------------
  logic [IR_W-1:0] ir_sh;
  logic [IR_W-1:0] ir_lat;
  logic [6:0] ir_op;
  logic sel_run;
  logic sel_readback;
  logic sel_ctl;
  logic test_mode;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ir_sh <= IR_RESET;
    else if (tck_rise && state == ST_CAP_IR)
      ir_sh <= IR_CAPTURE; // RQ20
    else if (tck_rise && state == ST_SHIFT_IR)
      ir_sh <= {pins.tdi, ir_sh[IR_W-1:1]}; // RQ21
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ir_lat <= IR_RESET;
    else if (tck_fall && state == ST_TLR)
      ir_lat <= IR_RESET;
    else if (tck_fall && state == ST_UPD_IR)
      ir_lat <= ir_sh;
  end

  // Top instruction bit is a don't-care
  assign ir_op = ir_lat[6:0];
  assign sel_run = (ir_op == IR_RUN_SELECTED_TEST);
  assign sel_readback = (ir_op == IR_BOUNDARY_READBACK_NORMAL) ||
                        (ir_op == IR_BOUNDARY_READBACK_TESTMODE);
  assign sel_ctl = (ir_op == IR_CONTROL_REG_SCAN_NORMAL) ||
                   (ir_op == IR_CONTROL_REG_SCAN_TESTMODE);
  assign test_mode = sel_run || // RQ22
                     (ir_op == IR_BOUNDARY_READBACK_TESTMODE) ||
                     (ir_op == IR_CONTROL_REG_SCAN_TESTMODE);

  // --------------------------------------------------------------
  // Software control
  // --------------------------------------------------------------
  logic run_en;
  logic running;
  brte_op_e op;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      run_en <= CTRL_RUN_EN_RESET;
    else if (wr_i && addr_i == REG_CTRL)
      run_en <= wdata_i[CTRL_RUN_EN_BIT];
  end

  assign running = sel_run && (state == ST_RTI) && run_en; // RQ2 RQ26

  // --------------------------------------------------------------
  // Bypass and test-operation select registers
  // --------------------------------------------------------------
  logic bypass_sh;
  logic [1:0] ctl_sh;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      bypass_sh <= 1'h0;
    else if (tck_rise && state == ST_CAP_DR)
      bypass_sh <= 1'h0; // RQ22
    else if (tck_rise && state == ST_SHIFT_DR)
      bypass_sh <= pins.tdi;
  end

  // Capture-DR leaves the shift stage alone
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ctl_sh <= OP_RESET;
    else if (tck_rise && state == ST_SHIFT_DR && sel_ctl)
      ctl_sh <= {pins.tdi, ctl_sh[1]}; // RQ23
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      op <= OP_RESET;
    else if (tck_fall && state == ST_UPD_DR && sel_ctl)
      op <= brte_op_e'(ctl_sh[1:0]); // RQ1
  end

  // --------------------------------------------------------------
  // Boundary chain: shift stages and shadow latches
  // --------------------------------------------------------------
  logic [CHAIN_W-1:0] sh;
  logic [CHAIN_W-1:0] shadow;
  logic dir_a_in;
  logic [7:0] in_pins;
  logic [7:0] in_cells;
  logic [7:0] out_cells;
  logic [15:0] step16;
  logic [7:0] in_step;
  logic [7:0] out_step;
  logic [7:0] next_in;
  logic [7:0] next_out;
  logic [15:0] next_cells;
  logic [15:0] in_mask;
  logic [15:0] upd_mask;

  assign dir_a_in = shadow[DIR_BIT]; // RQ6
  assign in_pins = dir_a_in ? pins.a : pins.b;
  assign in_cells = dir_a_in ? sh[A_LSB+:8] : sh[B_LSB+:8];
  assign out_cells = dir_a_in ? sh[B_LSB+:8] : sh[A_LSB+:8];
  assign in_mask = dir_a_in ? 16'hFF00 : 16'h00FF;

  brte_lfsr_step #(
    .W(16),
    .TAPS(TAPS16)
  ) u_step16 (
    .q_i(sh[15:0]),
    .next_o(step16)
  ); // RQ25 RQ11

  brte_lfsr_step #(
    .W(8),
    .TAPS(TAPS8)
  ) u_step_in (
    .q_i(in_cells),
    .next_o(in_step)
  ); // RQ25

  brte_lfsr_step #(
    .W(8),
    .TAPS(TAPS8)
  ) u_step_out (
    .q_i(out_cells),
    .next_o(out_step)
  ); // RQ25 RQ11

  always_comb
  begin
    next_in = in_cells;
    next_out = out_cells;
    next_cells = sh[15:0];
    upd_mask = 16'hFFFF;
    case (op) // RQ3
      OP_SAMPLE_IN_TOGGLE_OUT:
      begin
        next_in = in_pins; // RQ7
        next_out = ~out_cells; // RQ8
        next_cells = dir_a_in ? {next_in, next_out} : {next_out, next_in};
      end
      OP_PATTERN_GENERATE:
        next_cells = step16; // RQ9
      OP_SIGNATURE_COMPRESS:
      begin
        next_cells = step16 ^ (dir_a_in ? {in_pins, 8'h00}
                                        : {8'h00, in_pins}); // RQ12
        upd_mask = in_mask; // RQ13
      end
      OP_COMBINED_COMPRESS_GENERATE:
      begin
        next_in = in_step ^ in_pins; // RQ14
        next_out = out_step; // RQ15
        next_cells = dir_a_in ? {next_in, next_out} : {next_out, next_in};
      end
      default:
        next_cells = sh[15:0];
    endcase
  end

  // Control cells never enter the algorithms, only the 16 data cells
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      sh <= CHAIN_RESET;
    else if (tck_rise && running)
      sh[15:0] <= next_cells; // RQ4
    else if (tck_rise && state == ST_SHIFT_DR && sel_readback)
      sh <= {pins.tdi, sh[CHAIN_W-1:1]}; // RQ24 RQ10
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      shadow <= CHAIN_RESET;
    else if (tck_fall && running)
      shadow[15:0] <= (shadow[15:0] & ~upd_mask) |
                      (sh[15:0] & upd_mask); // RQ13
    else if (tck_fall && state == ST_UPD_DR && sel_readback)
      shadow <= sh;
  end

  // --------------------------------------------------------------
  // Serial output
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo_o <= 1'h0;
      tdo_oe_o <= 1'h0;
    end
    else if (tck_fall)
    begin
      tdo_oe_o <= (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR); // RQ21
      if (state == ST_SHIFT_IR)
        tdo_o <= ir_sh[0];
      else if (sel_readback)
        tdo_o <= sh[0];
      else if (sel_ctl)
        tdo_o <= ctl_sh[0];
      else
        tdo_o <= bypass_sh; // RQ22
    end
  end

  // --------------------------------------------------------------
  // Transceiver pins and core data
  // --------------------------------------------------------------
  // Test mode only moves the pins on falling TCK; normal mode is a
  // plain transceiver and follows the inputs every cycle
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_o <= 8'h00;
      b_o <= 8'h00;
      a_oe_o <= 1'h0;
      b_oe_o <= 1'h0;
      core_data_o <= 8'h00;
    end
    else if (test_mode)
    begin
      if (tck_fall_q) // RQ17
      begin
        a_o <= shadow[A_LSB+:8];
        b_o <= shadow[B_LSB+:8];
        a_oe_o <= ~shadow[OE_BIT] & ~shadow[DIR_BIT]; // RQ5
        b_oe_o <= ~shadow[OE_BIT] & shadow[DIR_BIT]; // RQ5
        core_data_o <= dir_a_in ? shadow[A_LSB+:8] : shadow[B_LSB+:8];
      end
    end
    else
    begin
      a_o <= pins.b;
      b_o <= pins.a;
      a_oe_o <= ~pins.oe_n & ~pins.dir;
      b_oe_o <= ~pins.oe_n & pins.dir;
      core_data_o <= pins.dir ? pins.a : pins.b;
    end
  end

  // --------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= 32'h0000_0000;
    else if (rd_i)
      case (addr_i)
        REG_CTRL: rdata_o <= {31'h0000_0000, run_en};
        REG_STATUS: rdata_o <= {16'h0000, state, ir_lat, op, running,
                                test_mode};
        REG_CHAIN: rdata_o <= {14'h0000, sh};
        default: rdata_o <= 32'h0000_0000;
      endcase
    else
      rdata_o <= 32'h0000_0000;
  end

endmodule

// ===== tb/brte_engine_props.sv
module brte_engine_props (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic dir_i,
  input wire logic oe_n_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic [brte_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  input wire logic [7:0] a_o,
  input wire logic a_oe_o,
  input wire logic [7:0] b_o,
  input wire logic b_oe_o,
  input wire logic [7:0] core_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import brte_pkg::*;

  logic [2:0] tck_rises;

  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Saturates: only the walk out of reset matters here
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tck_rises <= 3'h0;
    else if ($rose(tck_i) && tck_rises != 3'h7)
      tck_rises <= tck_rises + 3'h1;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // A detected fall lands a few clocks after the pin, so look back
  sequence s_tck_was_low;
    !$past(tck_i, 2) && !$past(tck_i, 3);
  endsequence

  sequence s_shift_hold;
    tdo_oe_o [*7];
  endsequence

  property p_tdo_on_fall;
    $changed(tdo_o) |-> s_tck_was_low;
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall)
    else $error("tdo_o changed away from a TCK fall");

  property p_tdo_oe_on_fall;
    $changed(tdo_oe_o) |-> s_tck_was_low;
  endproperty
  a_tdo_oe_on_fall: assert property (p_tdo_oe_on_fall)
    else $error("tdo_oe_o changed away from a TCK fall");

  property p_shift_after_walk;
    $rose(tdo_oe_o) |-> tck_rises >= 3'h5;
  endproperty
  a_shift_after_walk: assert property (p_shift_after_walk)
    else $error("shift state reached in too few TCK rises");

  property p_shift_hold;
    $rose(tdo_oe_o) |-> s_shift_hold;
  endproperty
  a_shift_hold: assert property (p_shift_hold)
    else $error("tdo_oe_o shorter than one TCK period");

  property p_one_port_drives;
    !(a_oe_o && b_oe_o);
  endproperty
  a_one_port_drives: assert property (p_one_port_drives)
    else $error("both ports driven at once");

  property p_rdata_quiet;
    !$past(rd_i) |-> rdata_o == 32'h0000_0000;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data outside its cycle");

  property p_b_oe_on_fall;
    $changed(b_oe_o) && oe_n_i == $past(oe_n_i, 5)
      && dir_i == $past(dir_i, 5) |-> s_tck_was_low;
  endproperty
  a_b_oe_on_fall: assert property (p_b_oe_on_fall)
    else $error("b_oe_o changed away from a TCK fall");

  property p_b_data_on_fall;
    $changed(b_o) && a_i == $past(a_i, 5)
      && dir_i == $past(dir_i, 5) |-> s_tck_was_low;
  endproperty
  a_b_data_on_fall: assert property (p_b_data_on_fall)
    else $error("b_o changed away from a TCK fall");
endmodule

bind brte_engine brte_engine_props u_props (
  .clk_i, .rstn_i, .tck_i, .tms_i, .tdi_i, .dir_i, .oe_n_i, .a_i, .b_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .tdo_o, .tdo_oe_o, .a_o,
  .a_oe_o, .b_o, .b_oe_o, .core_data_o
);

// ===== tb/brte_jtag_master.sv
module brte_jtag_master (
  input wire logic clk_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // TCK rests low between frames
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // One 80 ns TCK period; TDO is taken just before the fall
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    tdo = tdo_i;
    tck_o <= 1'b0;
  endtask

  // Idle, one IR or DR scan of n bits LSB first, back to idle
  task automatic scan(input logic ir, input int n, input logic [17:0] din,
                      output logic [17:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b0, t);
    if (ir)
      step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
    step(1'b0, 1'b0, t);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'b1, 1'b0, t);
    step(1'b0, 1'b0, t);
  endtask
endmodule

// ===== tb/tb_boundary_run_test_engine.sv
module tb_boundary_run_test_engine;
  timeunit 1ns;
  timeprecision 1ps;
  import brte_pkg::*;

  localparam logic [7:0] A_DRV = 8'h5A;
  localparam logic [7:0] B_DRV = 8'hC3;

  logic clk, rstn, dir, oe_n, wr, rd, tck, tms, tdi, tdo, tdo_oe;
  logic a_oe, b_oe;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  logic [7:0] a_o, b_o, core, a_pin, b_pin;
  int fail_count = 0;
  int total_checks = 0;

  // Pin level is the device's drive when enabled, else the board's
  assign a_pin = a_oe ? a_o : A_DRV;
  assign b_pin = b_oe ? b_o : B_DRV;

  brte_engine dut (
    .clk_i(clk), .rstn_i(rstn), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .dir_i(dir), .oe_n_i(oe_n), .a_i(a_pin), .b_i(b_pin), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .a_o(a_o), .a_oe_o(a_oe), .b_o(b_o), .b_oe_o(b_oe),
    .core_data_o(core)
  );

  brte_jtag_master jm (
    .clk_i(clk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h got %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
  endtask

  // One run step of the boundary chain
  function automatic logic [17:0] model(input logic [1:0] op,
                                        input logic [17:0] c);
    logic [15:0] w;
    logic [7:0] p, i, o;
    int il, ol;
    il = c[17] ? A_LSB : B_LSB;
    ol = c[17] ? B_LSB : A_LSB;
    p = c[17] ? A_DRV : B_DRV;
    w = c[15:0];
    i = w[il +: 8];
    o = w[ol +: 8];
    case (op)
      2'h0: w[il +: 8] = p;
      2'h3: w[il +: 8] = {i[6:0], ^(i & TAPS8)} ^ p;
      default: w = {w[14:0], ^(w & TAPS16)};
    endcase
    if (op == 2'h0)
      w[ol +: 8] = ~o;
    if (op == 2'h2)
      w[il +: 8] = w[il +: 8] ^ p;
    if (op == 2'h3)
      w[ol +: 8] = {o[6:0], ^(o & TAPS8)};
    return {c[17:16], w};
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    reg_rd(REG_STATUS, r);
    chk("status", {16'h0000, ST_TLR, IR_RESET, 4'h0}, r);
    reg_wr(REG_STATUS, 32'hFFFF_FFFF);
    reg_rd(REG_STATUS, r);
    chk("status_ro", {16'h0000, ST_TLR, IR_RESET, 4'h0}, r);
    reg_rd(REG_CTRL, r);
    chk("ctrl", 32'h0000_0001, r);
    reg_rd(4'hC, r);
    chk("unmapped", 32'h0000_0000, r);
    reg_rd(REG_CHAIN, r);
    chk("chain_reset", 32'(CHAIN_RESET), r);
  endtask

  task automatic t_capture();
    logic [17:0] d;
    logic t;
    jm.step(1'b0, 1'b0, t);
    jm.scan(1'b1, IR_W, {11'h000, IR_CONTROL_REG_SCAN_TESTMODE}, d);
    chk("ir_capture", 32'(IR_CAPTURE), 32'(d));
    jm.scan(1'b0, 2, 18'h0_0003, d);
    chk("ctrl_capture", 32'h0000_0000, 32'(d));
    jm.scan(1'b0, 2, 18'h0_0001, d);
    chk("ctrl_capture", 32'h0000_0003, 32'(d));
    jm.scan(1'b1, IR_W, {11'h000, IR_RUN_SELECTED_TEST}, d);
    jm.scan(1'b0, 3, 18'h0_0005, d);
    chk("bypass", 32'h0000_0002, 32'(d));
  endtask

  task automatic t_run(input logic [1:0] op, input logic [17:0] seed,
                       input logic en);
    logic [17:0] d, e;
    logic [31:0] r;
    logic t;
    int il, ol;
    il = seed[17] ? A_LSB : B_LSB;
    ol = seed[17] ? B_LSB : A_LSB;
    jm.scan(1'b1, IR_W, {11'h000, IR_BOUNDARY_READBACK_TESTMODE}, d);
    jm.scan(1'b0, CHAIN_W, seed, d);
    jm.scan(1'b1, IR_W, {11'h000, IR_CONTROL_REG_SCAN_TESTMODE}, d);
    jm.scan(1'b0, 2, {16'h0000, op}, d);
    jm.scan(1'b1, IR_W, {11'h000, IR_RUN_SELECTED_TEST}, d);
    if (!en)
      reg_wr(REG_CTRL, 32'h0000_0000);
    e = seed;
    for (int k = 0; k < 5; k++)
    begin
      jm.step(1'b0, 1'b0, t);
      if (en)
        e = model(op, e);
    end
    repeat (8) @(posedge clk);
    reg_rd(REG_CHAIN, r);
    chk("chain", 32'(e), r);
    reg_rd(REG_STATUS, r);
    chk("ir_op", {22'h0, 1'b0, IR_RUN_SELECTED_TEST, op}, 32'(r[11:2]));
    chk("out_pins", 32'(op == 2'h2 ? seed[ol +: 8] : e[ol +: 8]),
        32'(seed[17] ? b_o : a_o));
    chk("core", 32'(e[il +: 8]), 32'(core));
    chk("out_oe", 32'(!seed[16]), 32'(seed[17] ? b_oe : a_oe));
    chk("in_oe", 32'h0000_0000, 32'(seed[17] ? a_oe : b_oe));
    if (!en)
      reg_wr(REG_CTRL, 32'h0000_0001);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    dir = 1'b1;
    oe_n = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_capture();
    t_run(2'h0, 18'h2_A5F0, 1'b1);
    t_run(2'h1, 18'h2_1234, 1'b1);
    t_run(2'h2, 18'h2_BEEF, 1'b1);
    t_run(2'h3, 18'h2_8C31, 1'b1);
    t_run(2'h1, 18'h2_0000, 1'b1);
    t_run(2'h3, 18'h2_0000, 1'b1);
    t_run(2'h0, 18'h0_3C96, 1'b1);
    t_run(2'h0, 18'h3_3C96, 1'b1);
    t_run(2'h2, 18'h2_1111, 1'b0);
    test_done();
  end

  // Cuts a hang short
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule
